// >>> spls_pkg.sv
// constants and types shared by the serial port link sequencer
`default_nettype none
package spls_pkg;
   // ----------------------------------------
   // geometry
   // ----------------------------------------
   localparam int unsigned NUM_PORTS = 4;
   localparam int unsigned PORT_W    = 2;
   localparam int unsigned PKT_W     = 8;
   localparam int unsigned SET_W     = 16;
   localparam int unsigned IRQ_W     = 3;

   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_PKTCFG  = 8'h04;
   localparam logic [7:0] ADDR_STATUS  = 8'h08;
   localparam logic [7:0] ADDR_IRQSTAT = 8'h0C;
   localparam logic [7:0] ADDR_IRQMASK = 8'h10;
   localparam logic [3:0] PAGE_PARAMS  = 4'h2;
   localparam logic [3:0] PAGE_TMO     = 4'h3;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int unsigned CTRL_START = 0;
   localparam int unsigned CTRL_PAUSE = 1;
   localparam int unsigned CTRL_ABORT = 2;
   localparam int unsigned CTRL_AUTO  = 3;
   localparam int unsigned CTRL_PORT  = 4;
   localparam int unsigned CTRL_W     = 6;
   localparam int unsigned PKTCFG_RX  = 8;
   localparam int unsigned PKTCFG_W   = 9;
   localparam int unsigned ST_ACT     = 0;
   localparam int unsigned ST_ERR     = 1;
   localparam int unsigned ST_DONE    = 2;
   localparam int unsigned ST_WAIT    = 3;
   localparam int unsigned ST_PKT     = 8;
   localparam int unsigned ST_READY   = 16;
   localparam int unsigned ST_FIN     = 20;
   localparam int unsigned IRQ_DONE   = 0;
   localparam int unsigned IRQ_ERR    = 1;
   localparam int unsigned IRQ_HALT   = 2;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [15:0] PARAM_RESET = 16'h0000;
   localparam logic [15:0] TMO_RESET   = 16'h0032;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int unsigned CLK_PERIOD_NS   = 100;
   localparam int unsigned TMO_UNIT_NS     = 10_000_000;
   localparam int unsigned TMO_TICK_CYCLES = TMO_UNIT_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {ST_IDLE, ST_STANDBY, ST_SEND, ST_RECV} spls_state_t;
endpackage
`default_nettype wire

// >>> spls_reset_sync.sv
// two-stage release of the asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module spls_reset_sync (
   // clock and raw reset
   input  wire logic mclk,
   input  wire logic reset_n,
   // released reset
   output logic      rstSyncN
);
   typedef struct packed {
      logic stage1;
      logic stage2;
   } spls_rsync_t;

   spls_rsync_t q;
   spls_rsync_t d;

   always_comb begin
      d.stage1 = 1'b1;
      d.stage2 = q.stage1;
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign rstSyncN = q.stage2;
endmodule // spls_reset_sync
`default_nettype wire

// >>> spls_rx_timer.sv
// reply timeout counter in 0.01 s units
`timescale 1ns/1ps
`default_nettype none
module spls_rx_timer #(
   parameter int unsigned TICK_CYCLES = spls_pkg::TMO_TICK_CYCLES
) (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rstSyncN,
   // control
   input  wire logic       run,
   input  wire logic [7:0] limit,
   // result
   output logic            expired
);
   localparam int unsigned PW = $clog2(TICK_CYCLES + 1);

   typedef struct packed {
      logic [PW-1:0] presc;
      logic [7:0]    units;
      logic          expired;
   } spls_timer_t;

   spls_timer_t q;
   spls_timer_t d;

   if (TICK_CYCLES < 1) begin : g_chk
      $error("tick length must be at least one cycle");
   end

   always_comb begin
      d = q;
      if (!run) begin
         d = '0;
      end else begin
         if (q.presc == PW'(TICK_CYCLES - 1)) begin
            d.presc = '0;
            if (q.units != 8'hFF) begin
               d.units = q.units + 8'h01;
            end
         end else begin
            d.presc = q.presc + PW'(1);
         end
         d.expired = (q.units >= limit);
      end
   end

   always_ff @(posedge mclk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign expired = q.expired;
endmodule // spls_rx_timer
`default_nettype wire

// >>> spls_top.sv
// serial port link sequencer with register slave
//
// Local design decisions: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [RULE1] start on rising edge, pause and abort low
// [RULE2] free port: take it, ready low, send
// [RULE3] busy port: standby, then start at once
// [RULE4] pause: finish data, then release port; in ST_RECV the code releases the port at once without waiting for the reply
// [RULE5] abort: cut transfer, release port at once
// [RULE6] acting high during whole transaction
// [RULE7] packet ends with error: done and error
// [RULE8] packet ends cleanly: done only
// [RULE9] ready low during transaction, high after
// [RULE10] ready rise restarts, packets wrap cyclically
// [RULE11] four ports each own their signal set
// [RULE12] many peripherals may share one port
// [RULE13] finished flag set on completed transaction
// [RULE14] timeout low byte, 0.01 s units, default 50
// [RULE15] new packet clears done and error
module spls_top #(
   parameter int unsigned TICK_CYCLES = spls_pkg::TMO_TICK_CYCLES
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset_n,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // port sharing
   input  wire logic [3:0]  otherHold,
   output logic [3:0]       portReady,
   output logic [3:0]       portFinished,
   // serial engine
   output logic             linkStart,
   output logic             linkAbort,
   output logic [1:0]       linkPort,
   output logic [7:0]       linkPacket,
   output logic             linkRecv,
   output logic [15:0]      linkParams,
   input  wire logic        linkTxDone,
   input  wire logic        linkRxDone,
   input  wire logic        linkRxError,
   // indications
   output logic             acting,
   output logic             errorInd,
   output logic             doneInd,
   output logic             irq
);
   typedef struct packed {
      spls_pkg::spls_state_t         state;
      logic [1:0]                    holdPort;
      logic                          hold;
      logic [spls_pkg::CTRL_W-1:0]   ctrl;
      logic [spls_pkg::PKTCFG_W-1:0] pktCfg;
      logic [3:0][15:0]              params;
      logic [3:0][15:0]              tmo;
      logic [spls_pkg::IRQ_W-1:0]    irqStat;
      logic [spls_pkg::IRQ_W-1:0]    irqMask;
      logic                          startPrev;
      logic                          readyPrev;
      logic [7:0]                    pktIdx;
      logic                          done;
      logic                          err;
      logic                          acting;
      logic [3:0]                    ready;
      logic [3:0]                    finished;
      logic                          linkStart;
      logic                          linkAbort;
      logic [15:0]                   linkParams;
      logic                          irq;
      logic [31:0]                   hrdata;
      logic                          hreadyout;
      logic                          aWrite;
      logic [7:0]                    aAddr;
   } spls_regs_t;

   spls_regs_t q;
   spls_regs_t d;
   logic       rstSyncN;
   logic       tmoExpired;
   logic       accept;
   logic       startEdge;
   logic       autoEdge;
   logic       trigger;
   logic       pauseBit;
   logic       abortBit;
   logic [1:0] selPort;

   // ----------------------------------------
   // reset and reply timer
   // ----------------------------------------
   spls_reset_sync u_rst (
      .mclk     (mclk),
      .reset_n  (reset_n),
      .rstSyncN (rstSyncN)
   );

   spls_rx_timer #(.TICK_CYCLES(TICK_CYCLES)) u_tmr (
      .mclk     (mclk),
      .rstSyncN (rstSyncN),
      .run      (q.state == spls_pkg::ST_RECV),
      .limit    (q.tmo[q.holdPort][7:0]), // RULE14
      .expired  (tmoExpired)
   );

   // ----------------------------------------
   // sequencer and register file
   // ----------------------------------------
   assign pauseBit  = q.ctrl[spls_pkg::CTRL_PAUSE];
   assign abortBit  = q.ctrl[spls_pkg::CTRL_ABORT];
   assign selPort   = q.ctrl[spls_pkg::CTRL_PORT +: 2];
   assign accept    = hsel && htrans[1] && hready;
   assign startEdge = q.ctrl[spls_pkg::CTRL_START] && !q.startPrev;
   assign autoEdge  = q.ctrl[spls_pkg::CTRL_AUTO] && q.ready[selPort] && !q.readyPrev; // RULE10
   assign trigger   = (startEdge || autoEdge) && !pauseBit && !abortBit; // RULE1

   always_comb begin
      logic [spls_pkg::IRQ_W-1:0] irqSet;
      logic [spls_pkg::IRQ_W-1:0] irqClr;
      logic                       take;
      logic                       finish;
      logic                       finErr;
      logic                       drop;
      irqSet  = '0;
      irqClr  = '0;
      take    = 1'b0;
      finish  = 1'b0;
      finErr  = 1'b0;
      drop    = 1'b0;
      d = q;
      d.linkStart = 1'b0;
      d.linkAbort = 1'b0;
      d.startPrev = q.ctrl[spls_pkg::CTRL_START];
      d.readyPrev = q.ready[selPort];

      unique case (q.state)
         spls_pkg::ST_IDLE: begin
            if (trigger) begin
               d.holdPort = selPort;
               if (!otherHold[selPort]) begin
                  take = 1'b1; // RULE2
               end else begin
                  d.state = spls_pkg::ST_STANDBY; // RULE3
               end
            end
         end
         spls_pkg::ST_STANDBY: begin
            if (abortBit) begin
               d.state = spls_pkg::ST_IDLE;
               irqSet[spls_pkg::IRQ_HALT] = 1'b1;
            end else if (!otherHold[q.holdPort]) begin
               take = 1'b1; // RULE3
            end
         end
         spls_pkg::ST_SEND: begin
            if (abortBit) begin
               d.linkAbort = 1'b1; // RULE5
               drop = 1'b1;
            end else if (linkTxDone) begin
               if (pauseBit) begin
                  drop = 1'b1; // RULE4
               end else if (q.pktCfg[spls_pkg::PKTCFG_RX]) begin
                  d.state = spls_pkg::ST_RECV;
               end else begin
                  finish = 1'b1;
               end
            end
         end
         spls_pkg::ST_RECV: begin
            if (abortBit) begin
               d.linkAbort = 1'b1; // RULE5
               drop = 1'b1;
            end else if (linkRxDone) begin
               finish = 1'b1;
               finErr = linkRxError;
            end else if (tmoExpired) begin
               finish = 1'b1; // RULE14
               finErr = 1'b1;
            end else if (pauseBit) begin
               drop = 1'b1; // RULE4
            end
         end
      endcase

      if (take) begin
         d.state      = spls_pkg::ST_SEND;
         d.hold       = 1'b1; // RULE2
         d.linkStart  = 1'b1;
         d.linkParams = q.params[d.holdPort];
         d.done       = 1'b0; // RULE15
         d.err        = 1'b0; // RULE15
         d.finished[d.holdPort] = 1'b0;
      end
      if (drop) begin
         d.state = spls_pkg::ST_IDLE;
         d.hold  = 1'b0; // RULE9
         irqSet[spls_pkg::IRQ_HALT] = 1'b1;
      end
      if (finish) begin
         d.state = spls_pkg::ST_IDLE;
         d.hold  = 1'b0; // RULE9
         d.done  = 1'b1; // RULE8
         d.err   = finErr; // RULE7
         d.finished[q.holdPort] = 1'b1; // RULE13
         d.pktIdx = (q.pktIdx == q.pktCfg[7:0]) ? 8'h00 : q.pktIdx + 8'h01; // RULE10
         irqSet[spls_pkg::IRQ_DONE] = 1'b1;
         irqSet[spls_pkg::IRQ_ERR]  = finErr;
      end
      d.acting = (d.state == spls_pkg::ST_SEND) || (d.state == spls_pkg::ST_RECV); // RULE6

      // per-port ready flags
      for (int p = 0; p < spls_pkg::NUM_PORTS; p++) begin
         d.ready[p] = !otherHold[p] && !(d.hold && d.holdPort == 2'(p)); // RULE11
      end

      // bus address phase and read data
      d.hreadyout = 1'b1;
      d.aWrite    = accept && hwrite && (hsize == 3'b010) && (haddr[31:8] == 24'h00_0000);
      d.aAddr     = haddr[7:0];
      if (accept && !hwrite) begin
         d.hrdata = 32'h0000_0000;
         if (haddr[31:8] == 24'h00_0000) begin
            if (haddr[7:0] == spls_pkg::ADDR_CTRL) begin
               d.hrdata[spls_pkg::CTRL_W-1:0] = q.ctrl;
            end else if (haddr[7:0] == spls_pkg::ADDR_PKTCFG) begin
               d.hrdata[spls_pkg::PKTCFG_W-1:0] = q.pktCfg;
            end else if (haddr[7:0] == spls_pkg::ADDR_STATUS) begin
               d.hrdata[spls_pkg::ST_ACT]      = q.acting;
               d.hrdata[spls_pkg::ST_ERR]      = q.err;
               d.hrdata[spls_pkg::ST_DONE]     = q.done;
               d.hrdata[spls_pkg::ST_WAIT]     = (q.state == spls_pkg::ST_STANDBY);
               d.hrdata[spls_pkg::ST_PKT +: 8] = q.pktIdx;
               d.hrdata[spls_pkg::ST_READY +: 4] = q.ready;
               d.hrdata[spls_pkg::ST_FIN +: 4]   = q.finished;
            end else if (haddr[7:0] == spls_pkg::ADDR_IRQSTAT) begin
               d.hrdata[spls_pkg::IRQ_W-1:0] = q.irqStat;
               irqClr = q.irqStat;
            end else if (haddr[7:0] == spls_pkg::ADDR_IRQMASK) begin
               d.hrdata[spls_pkg::IRQ_W-1:0] = q.irqMask;
            end else if (haddr[7:4] == spls_pkg::PAGE_PARAMS) begin
               d.hrdata[15:0] = q.params[haddr[3:2]];
            end else if (haddr[7:4] == spls_pkg::PAGE_TMO) begin
               d.hrdata[15:0] = q.tmo[haddr[3:2]];
            end
         end
      end

      // bus data phase writes
      if (q.aWrite) begin
         if (q.aAddr == spls_pkg::ADDR_CTRL) begin
            d.ctrl = hwdata[spls_pkg::CTRL_W-1:0];
         end else if (q.aAddr == spls_pkg::ADDR_PKTCFG) begin
            d.pktCfg = hwdata[spls_pkg::PKTCFG_W-1:0];
         end else if (q.aAddr == spls_pkg::ADDR_IRQMASK) begin
            d.irqMask = hwdata[spls_pkg::IRQ_W-1:0];
         end else if (q.aAddr[7:4] == spls_pkg::PAGE_PARAMS) begin
            d.params[q.aAddr[3:2]] = hwdata[15:0];
         end else if (q.aAddr[7:4] == spls_pkg::PAGE_TMO) begin
            d.tmo[q.aAddr[3:2]] = hwdata[15:0];
         end
      end

      // sticky events, set wins over read clear
      d.irqStat = (q.irqStat & ~irqClr) | irqSet;
      d.irq     = |(d.irqStat & d.irqMask);
   end

   always_ff @(posedge mclk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         q        <= '0;
         q.ready  <= 4'hF;
         q.readyPrev <= 1'b1;
         q.params <= {4{spls_pkg::PARAM_RESET}};
         q.tmo    <= {4{spls_pkg::TMO_RESET}}; // RULE14
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign hrdata       = q.hrdata;
   assign hreadyout    = q.hreadyout;
   assign hresp        = q.aWrite && 1'b0;
   assign portReady    = q.ready;
   assign portFinished = q.finished;
   assign linkStart    = q.linkStart;
   assign linkAbort    = q.linkAbort;
   assign linkPort     = q.holdPort;
   assign linkPacket   = q.pktIdx;
   assign linkRecv     = q.pktCfg[spls_pkg::PKTCFG_RX];
   assign linkParams   = q.linkParams;
   assign acting       = q.acting;
   assign errorInd     = q.err;
   assign doneInd      = q.done;
   assign irq          = q.irq;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_START_GUARD: assert property (@(posedge mclk) disable iff (!rstSyncN) // RULE1
      (q.state == spls_pkg::ST_IDLE) ##1 (q.state != spls_pkg::ST_IDLE)
      |-> $past(trigger)) else $error("sequence left idle without a clean start edge");
   AST_TAKE_READY: assert property (@(posedge mclk) disable iff (!rstSyncN) // RULE2
      $rose(acting) |-> !portReady[linkPort] && linkStart) else $error("port taken but ready flag still high");
   AST_STANDBY_GO: assert property (@(posedge mclk) disable iff (!rstSyncN) // RULE3
      (q.state == spls_pkg::ST_STANDBY && !otherHold[q.holdPort] && !abortBit)
      |=> acting) else $error("standby did not start when port freed");
   AST_PAUSE_HOLD: assert property (@(posedge mclk) disable iff (!rstSyncN) // RULE4
      (q.state == spls_pkg::ST_SEND && pauseBit && !abortBit && !linkTxDone)
      |=> q.state == spls_pkg::ST_SEND) else $error("pause cut data in progress");
   AST_ABORT_NOW: assert property (@(posedge mclk) disable iff (!rstSyncN) // RULE5
      (acting && abortBit) |=> !acting && linkAbort && !q.hold) else $error("abort did not release at once");
   AST_ACT_LEVEL: assert property (@(posedge mclk) disable iff (!rstSyncN) // RULE6
      acting |-> q.hold && !portReady[linkPort]) else $error("acting without holding the port");
   AST_ERR_DONE: assert property (@(posedge mclk) disable iff (!rstSyncN) // RULE7
      (q.state == spls_pkg::ST_RECV && !abortBit && !linkRxDone && tmoExpired)
      |=> doneInd && errorInd) else $error("timeout did not raise done and error");
   AST_OK_DONE: assert property (@(posedge mclk) disable iff (!rstSyncN) // RULE8
      (q.state == spls_pkg::ST_RECV && !abortBit && linkRxDone && !linkRxError)
      |=> doneInd && !errorInd && !acting) else $error("clean packet end misreported");
   AST_READY_BACK: assert property (@(posedge mclk) disable iff (!rstSyncN) // RULE9
      ($fell(acting) && !$past(otherHold[linkPort])) |-> portReady[linkPort])
      else $error("ready flag not restored after transaction");
   AST_WRAP: assert property (@(posedge mclk) disable iff (!rstSyncN) // RULE10
      ($rose(doneInd) && $past(linkPacket) == q.pktCfg[7:0]) |-> linkPacket == 8'h00)
      else $error("packet index did not wrap");
   AST_FINISHED: assert property (@(posedge mclk) disable iff (!rstSyncN) // RULE13
      $rose(doneInd) |-> portFinished[linkPort]) else $error("finished flag not set");
   AST_CLEAR: assert property (@(posedge mclk) disable iff (!rstSyncN) // RULE15
      $rose(acting) |-> !doneInd && !errorInd) else $error("done or error kept into new packet");
endmodule // spls_top
`default_nettype wire

// >>> spls_engine_model.sv
// serial engine model on the far side of the link
`timescale 1ns/1ps
`default_nettype none
module spls_engine_model #(
   parameter int TX_CYC = 12,
   parameter int RX_CYC = 6
) (
   // clock
   input  wire logic mclk,
   // requests from the sequencer
   input  wire logic linkStart,
   input  wire logic linkAbort,
   input  wire logic linkRecv,
   // scenario control
   input  wire logic rxErr,
   input  wire logic rxMute,
   // answers
   output logic      linkTxDone,
   output logic      linkRxDone,
   output logic      linkRxError
);
   int   cnt;
   logic tx;
   logic rx;
   initial begin
      cnt = 0;
      tx = 0;
      rx = 0;
      linkTxDone = 0;
      linkRxDone = 0;
      linkRxError = 0;
   end
   // error line is only meaningful with a reply, so it wanders otherwise
   always @(posedge mclk) begin
      linkTxDone <= 1'b0;
      linkRxDone <= 1'b0;
      linkRxError <= ~linkRxError;
      if (linkAbort) begin
         tx <= 1'b0;
         rx <= 1'b0;
      end else if (linkStart) begin
         tx <= 1'b1;
         rx <= 1'b0;
         cnt <= TX_CYC;
      end else if (tx) begin
         if (cnt == 0) begin
            tx <= 1'b0;
            linkTxDone <= 1'b1;
            rx <= linkRecv;
            cnt <= RX_CYC;
         end else begin
            cnt <= cnt - 1;
         end
      end else if (rx) begin
         if (cnt == 0) begin
            rx <= 1'b0;
            // reply from any station on the multidrop line
            if (!rxMute) begin
               linkRxDone <= 1'b1;
               linkRxError <= rxErr;
            end
         end else begin
            cnt <= cnt - 1;
         end
      end
   end
endmodule // spls_engine_model
`default_nettype wire

// >>> tb.sv
// self-checking testbench for the serial port link sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        mclk, reset_n, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans, linkPort;
   logic [2:0]  hsize;
   logic [3:0]  otherHold, portReady, portFinished;
   logic        linkStart, linkAbort, linkRecv, linkTxDone, linkRxDone, linkRxError;
   logic [7:0]  linkPacket, pk;
   logic [15:0] linkParams;
   logic        acting, errorInd, doneInd, irq, rxErr, rxMute;
   int          n_fail, comparisons, k;
   // rows: receive mode, bad reply, no reply, error expected
   logic [3:0]  rows [4] = '{4'b0000, 4'b1000, 4'b1101, 4'b1011};
   assign hready = hreadyout;
   spls_top #(.TICK_CYCLES(4)) dut (.mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .otherHold(otherHold),
      .portReady(portReady), .portFinished(portFinished), .linkStart(linkStart),
      .linkAbort(linkAbort), .linkPort(linkPort), .linkPacket(linkPacket), .linkRecv(linkRecv),
      .linkParams(linkParams), .linkTxDone(linkTxDone), .linkRxDone(linkRxDone),
      .linkRxError(linkRxError), .acting(acting), .errorInd(errorInd), .doneInd(doneInd), .irq(irq));
   spls_engine_model eng (.mclk(mclk), .linkStart(linkStart), .linkAbort(linkAbort),
      .linkRecv(linkRecv), .rxErr(rxErr), .rxMute(rxMute), .linkTxDone(linkTxDone),
      .linkRxDone(linkRxDone), .linkRxError(linkRxError));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      haddr <= {24'h00_0000, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic go(input logic [1:0] p, input logic [3:0] f);
      bus(1'b1, 8'h00, {26'h000_0000, p, 4'h0});
      bus(1'b1, 8'h00, {26'h000_0000, p, f});
   endtask
   task automatic waitAct(input logic v);
      for (k = 0; k < 300 && acting !== v; k++) @(posedge mclk);
   endtask
   task automatic finish_test();
      $display("comparisons %0d failures %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ----------------------------------------
   // clock, watchdog, sequence
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   initial begin
      #2_000_000;
      n_fail++;
      finish_test();
   end
   initial begin
      reset_n = 0; hsel = 1; hsize = 3'b010; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0;
      otherHold = 0; rxErr = 0; rxMute = 0; n_fail = 0; comparisons = 0;
      repeat (10) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (4) @(posedge mclk);
      bus(1'b0, 8'h30, 0); chk("tmo reset", 32'h0000_0032, rd);
      bus(1'b0, 8'h20, 0); chk("param reset", 0, rd);
      bus(1'b0, 8'h44, 0); chk("unmapped", 0, rd);
      chk("ready reset", 4'hf, portReady);
      chk("hresp", 0, hresp);
      $display("reset test ended");
      bus(1'b1, 8'h3c, 32'h0000_0002);
      bus(1'b1, 8'h24, 32'h0000_1234);
      for (int i = 0; i < 4; i++) begin
         rxErr <= rows[i][2];
         rxMute <= rows[i][1];
         bus(1'b1, 8'h04, {23'h00_0000, rows[i][3], 8'h01});
         go(i[1:0], 4'h1);
         waitAct(1'b1);
         chk("acting", 1, acting);
         chk("ready low", 0, portReady[i]);
         chk("port", i, linkPort);
         chk("packet", i % 2, linkPacket);
         chk("done cleared", 0, doneInd);
         chk("recv mode", rows[i][3], linkRecv);
         if (i == 1) chk("params", 32'h0000_1234, linkParams);
         waitAct(1'b0);
         @(posedge mclk);
         chk("done", 1, doneInd);
         chk("error", rows[i][0], errorInd);
         chk("finished", 1, portFinished[i]);
         chk("ready high", 1, portReady[i]);
         $display("row %0d ended", i);
      end
      chk("irq masked", 0, irq);
      bus(1'b1, 8'h10, 32'h0000_0007);
      @(posedge mclk);
      chk("irq", 1, irq);
      bus(1'b0, 8'h0c, 0); chk("irq status", 32'h0000_0003, rd);
      bus(1'b0, 8'h0c, 0); chk("irq cleared", 0, rd);
      chk("irq low", 0, irq);
      $display("interrupt test ended");
      bus(1'b1, 8'h04, 32'h0000_0001);
      otherHold <= 4'h1;
      go(2'h0, 4'h1);
      repeat (5) @(posedge mclk);
      chk("standby", 0, acting);
      bus(1'b0, 8'h08, 0); chk("standby bit", 1, rd[3]);
      otherHold <= 4'h0;
      repeat (3) @(posedge mclk);
      chk("standby leave", 1, acting);
      bus(1'b1, 8'h00, 32'h0000_0003);
      chk("pause finishing", 1, acting);
      waitAct(1'b0);
      @(posedge mclk);
      chk("pause done", 0, doneInd);
      chk("pause ready", 1, portReady[0]);
      bus(1'b0, 8'h0c, 0); chk("halt irq", 32'h0000_0004, rd);
      $display("standby and pause test ended");
      for (int f = 3; f <= 5; f += 2) begin
         go(2'h1, f[3:0]);
         repeat (6) @(posedge mclk);
         chk("blocked start", 0, acting);
      end
      $display("blocked start test ended");
      go(2'h2, 4'h9);
      waitAct(1'b1);
      pk = linkPacket;
      waitAct(1'b0);
      waitAct(1'b1);
      chk("auto next", {pk[7:1], ~pk[0]}, linkPacket);
      bus(1'b1, 8'h00, 32'h0000_002d);
      for (k = 0; k < 20 && linkAbort !== 1'b1; k++) @(posedge mclk);
      chk("abort pulse", 1, linkAbort);
      repeat (2) @(posedge mclk);
      chk("abort acting", 0, acting);
      chk("abort ready", 1, portReady[2]);
      chk("abort done", 0, doneInd);
      bus(1'b1, 8'h00, 0);
      $display("auto cycle and abort test ended");
      finish_test();
   end
endmodule // tb
`default_nettype wire
